/* hw/emr_router.sv */
module emr_router
   import emr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [15:0] error_status_register,
   input wire logic msg_ready,
   output logic msg_valid,
   output emr_msg_t msg_kind,
   output logic [3:0] msg_source
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   emr_state_t s_q;
   emr_state_t s_d;
   logic [15:0] rise;
   logic [15:0] rd_val;
   logic take;
   logic [15:0] serr_all;
   logic [15:0] smi_all;
   logic [15:0] sci_all;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign msg_valid = s_q.msg.valid;
   assign msg_kind = s_q.msg.kind;
   assign msg_source = s_q.msg.source;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      rd_val = 16'h0000;
      take = hsel && hready && htrans == EMR_HTRANS_NONSEQ && hsize == EMR_HSIZE_WORD;
      // edge only: a flag held set by its owner sends one message per enabled kind, not a stream
      rise = error_status_register & ~s_q.flag_prev;
      s_d.flag_prev = error_status_register;
      // system-error needs the per-source enable and the global command enable
      if (s_q.serr_global) begin
         s_d.pend_serr = s_q.pend_serr | (rise & s_q.serr_en);
      end
      s_d.pend_smi = s_q.pend_smi | (rise & s_q.smi_en);
      s_d.pend_sci = s_q.pend_sci | (rise & s_q.sci_en);
      // data phase write
      if (s_q.a_valid && s_q.a_write) begin
         if (s_q.a_addr == EMR_ADDR_SERR) begin
            s_d.serr_en = hwdata[15:0] & EMR_SERR_MASK;
         end else if (s_q.a_addr == EMR_ADDR_SMI) begin
            s_d.smi_en = hwdata[15:0] & EMR_ECC_MASK;
         end else if (s_q.a_addr == EMR_ADDR_SCI) begin
            s_d.sci_en = hwdata[15:0] & EMR_ECC_MASK;
         end else if (s_q.a_addr == EMR_ADDR_CTRL) begin
            s_d.serr_global = hwdata[EMR_BIT_CMD_SERR];
         end
      end
      // address phase, read data registered for the next cycle
      s_d.a_valid = take;
      s_d.a_write = hwrite;
      s_d.a_addr = haddr[9:0];
      if (haddr[9:0] == EMR_ADDR_SERR) begin
         rd_val = s_q.serr_en;
      end else if (haddr[9:0] == EMR_ADDR_SMI) begin
         rd_val = s_q.smi_en;
      end else if (haddr[9:0] == EMR_ADDR_SCI) begin
         rd_val = s_q.sci_en;
      end else if (haddr[9:0] == EMR_ADDR_CTRL) begin
         rd_val = {15'h0000, s_q.serr_global};
      end else if (haddr[9:0] == EMR_ADDR_STAT) begin
         rd_val = s_q.pend_serr | s_q.pend_smi | s_q.pend_sci;
      end
      s_d.rdata = (take && !hwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
      // hub message out: errors only leave as messages, never on a pin
      if (s_q.msg.valid && msg_ready) begin
         s_d.msg.valid = 1'b0;
      end
      serr_all = s_d.pend_serr;
      smi_all = s_d.pend_smi;
      sci_all = s_d.pend_sci;
      if (!s_d.msg.valid) begin
         // system-error before management before control; within one kind, lowest source first
         for (int i = 15; i >= 0; i--) begin
            if (sci_all[i]) begin
               s_d.msg = '{valid: 1'b1, kind: EMR_MSG_SCI, source: 4'(i)};
            end
         end
         for (int i = 15; i >= 0; i--) begin
            if (smi_all[i]) begin
               s_d.msg = '{valid: 1'b1, kind: EMR_MSG_SMI, source: 4'(i)};
            end
         end
         for (int i = 15; i >= 0; i--) begin
            if (serr_all[i]) begin
               s_d.msg = '{valid: 1'b1, kind: EMR_MSG_SERR, source: 4'(i)};
            end
         end
         if (s_d.msg.valid) begin
            if (s_d.msg.kind == EMR_MSG_SERR) begin
               s_d.pend_serr[s_d.msg.source] = 1'b0;
            end else if (s_d.msg.kind == EMR_MSG_SMI) begin
               s_d.pend_smi[s_d.msg.source] = 1'b0;
            end else begin
               s_d.pend_sci[s_d.msg.source] = 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   route_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> s_q.serr_en == EMR_ROUTE_RST
      && s_q.smi_en == EMR_ROUTE_RST && s_q.sci_en == EMR_ROUTE_RST) else $error("routing not zero");
   reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.serr_en & ~EMR_SERR_MASK) == 16'h0000 && (s_q.smi_en & ~EMR_ECC_MASK) == 16'h0000)
      else $error("reserved bit set");
   serr_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(!s_q.serr_global) && $past(s_q.pend_serr) == 16'h0000 |-> s_q.pend_serr == 16'h0000)
      else $error("serr queued while disabled");
   serr_queue_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.serr_global && s_q.serr_en[5] && error_status_register[5] && !s_q.flag_prev[5]
      |=> s_q.pend_serr[5] || (s_q.msg.valid && s_q.msg.source == 4'd5)) else $error("serr lost");
   held_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.flag_prev[7] && error_status_register[7] && s_q.pend_smi[7] == 1'b0
      |=> !s_q.pend_smi[7]) else $error("repeat message");
   msg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_valid && !msg_ready |=> msg_valid && $stable(msg_source) && $stable(msg_kind))
      else $error("message dropped");
   smi_queue_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.smi_en[8] && error_status_register[8] && !s_q.flag_prev[8]
      |=> s_q.pend_smi[8] || (msg_valid && msg_kind == EMR_MSG_SMI)) else $error("smi lost");
   sci_queue_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.sci_en[7] && error_status_register[7] && !s_q.flag_prev[7]
      |=> s_q.pend_sci[7] || (msg_valid && msg_kind == EMR_MSG_SCI)) else $error("sci lost");

   // ------------------------------------------------------------
   // register bus checks
   // ------------------------------------------------------------
   sci_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_q.sci_en & ~EMR_ECC_MASK) == 16'h0000)
      else $error("reserved control bit set");
   upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hrdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   serr_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(s_q.a_valid && s_q.a_write && s_q.a_addr == EMR_ADDR_SERR)
      |-> s_q.serr_en == ($past(hwdata[15:0]) & EMR_SERR_MASK))
      else $error("system-error enable write lost");
   smi_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(s_q.a_valid && s_q.a_write && s_q.a_addr == EMR_ADDR_SMI)
      |-> s_q.smi_en == ($past(hwdata[15:0]) & EMR_ECC_MASK))
      else $error("management enable write lost");
   sci_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(s_q.a_valid && s_q.a_write && s_q.a_addr == EMR_ADDR_SCI)
      |-> s_q.sci_en == ($past(hwdata[15:0]) & EMR_ECC_MASK))
      else $error("control enable write lost");
   ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(s_q.a_valid && s_q.a_write && s_q.a_addr == EMR_ADDR_CTRL)
      |-> s_q.serr_global == $past(hwdata[EMR_BIT_CMD_SERR]))
      else $error("global enable write lost");

   // ------------------------------------------------------------
   // message link checks
   // ------------------------------------------------------------
   msg_reset_a: assert property (@(posedge hclk)
      $rose(hresetn) |-> !msg_valid && s_q.pend_serr == 16'h0000)
      else $error("message after reset");
   msg_kind_a: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_valid |-> msg_kind inside {EMR_MSG_SERR, EMR_MSG_SMI, EMR_MSG_SCI})
      else $error("bad message kind");
   ecc_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_valid && msg_kind != EMR_MSG_SERR |-> msg_source == 4'd7 || msg_source == 4'd8)
      else $error("interrupt from non-ecc source");
   serr_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_valid && msg_kind == EMR_MSG_SERR |-> msg_source >= 4'd1 && msg_source <= 4'd9)
      else $error("system-error from reserved source");
   msg_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
      msg_valid && msg_ready && rise == 16'h0000 && s_q.pend_serr == 16'h0000
      && s_q.pend_smi == 16'h0000 && s_q.pend_sci == 16'h0000 |=> !msg_valid)
      else $error("message repeated");

   // ------------------------------------------------------------
   // per-source checks
   // ------------------------------------------------------------
   // one copy per status bit, so a fault in one source's path shows by itself
   for (genvar g = 0; g < 16; g++) begin : src_g
      serr_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !s_q.serr_en[g] && !s_q.pend_serr[g] |=> !s_q.pend_serr[g])
         else $error("system-error from disabled source");
      global_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !s_q.serr_global && !s_q.pend_serr[g] |=> !s_q.pend_serr[g])
         else $error("system-error while globally off");
      smi_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !s_q.smi_en[g] && !s_q.pend_smi[g] |=> !s_q.pend_smi[g])
         else $error("management from disabled source");
      sci_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !s_q.sci_en[g] && !s_q.pend_sci[g] |=> !s_q.pend_sci[g])
         else $error("control from disabled source");
      serr_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
         s_q.serr_global && s_q.serr_en[g] && error_status_register[g] && !s_q.flag_prev[g]
         |=> s_q.pend_serr[g] || (msg_valid && msg_kind == EMR_MSG_SERR && msg_source == 4'(g)))
         else $error("system-error event lost");
      smi_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
         s_q.smi_en[g] && error_status_register[g] && !s_q.flag_prev[g]
         |=> s_q.pend_smi[g] || (msg_valid && msg_kind == EMR_MSG_SMI && msg_source == 4'(g)))
         else $error("management event lost");
      sci_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
         s_q.sci_en[g] && error_status_register[g] && !s_q.flag_prev[g]
         |=> s_q.pend_sci[g] || (msg_valid && msg_kind == EMR_MSG_SCI && msg_source == 4'(g)))
         else $error("control event lost");
      no_repeat_a: assert property (@(posedge hclk) disable iff (!hresetn)
         s_q.flag_prev[g] && !s_q.pend_serr[g] && !s_q.pend_smi[g] && !s_q.pend_sci[g]
         |=> !s_q.pend_serr[g] && !s_q.pend_smi[g] && !s_q.pend_sci[g])
         else $error("held flag queued again");
   end

endmodule

/* hw/emr_pkg.sv */
package emr_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   // printed offsets are not all multiples of four: they are indices, byte address is index * 4
   localparam logic [7:0] EMR_IDX_SERR = 8'hCA;
   localparam logic [7:0] EMR_IDX_SMI = 8'hCC;
   localparam logic [7:0] EMR_IDX_SCI = 8'hCE;
   localparam logic [7:0] EMR_IDX_CTRL = 8'hD0;
   localparam logic [7:0] EMR_IDX_STAT = 8'hD2;
   localparam logic [9:0] EMR_ADDR_SERR = {EMR_IDX_SERR, 2'b00};
   localparam logic [9:0] EMR_ADDR_SMI = {EMR_IDX_SMI, 2'b00};
   localparam logic [9:0] EMR_ADDR_SCI = {EMR_IDX_SCI, 2'b00};
   localparam logic [9:0] EMR_ADDR_CTRL = {EMR_IDX_CTRL, 2'b00};
   localparam logic [9:0] EMR_ADDR_STAT = {EMR_IDX_STAT, 2'b00};

   // ------------------------------------------------------------
   // fields and resets
   // ------------------------------------------------------------
   localparam int EMR_NSRC = 10;
   localparam logic [15:0] EMR_SERR_MASK = 16'h03FE;
   localparam logic [15:0] EMR_ECC_MASK = 16'h0180;
   localparam logic [15:0] EMR_ROUTE_RST = 16'h0000;
   localparam int EMR_BIT_CMD_SERR = 0;
   localparam logic [1:0] EMR_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] EMR_HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      EMR_MSG_SERR,
      EMR_MSG_SMI,
      EMR_MSG_SCI
   } emr_msg_t;

   typedef struct packed {
      logic valid;
      emr_msg_t kind;
      logic [3:0] source;
   } emr_msg_pkt_t;

   typedef struct packed {
      logic [15:0] serr_en;
      logic [15:0] smi_en;
      logic [15:0] sci_en;
      logic serr_global;
      logic [15:0] flag_prev;
      logic [15:0] pend_serr;
      logic [15:0] pend_smi;
      logic [15:0] pend_sci;
      logic [9:0] a_addr;
      logic a_write;
      logic a_valid;
      logic [31:0] rdata;
      emr_msg_pkt_t msg;
   } emr_state_t;

endpackage

/* bench/emr_hub_model.sv */
module emr_hub_model
   import emr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic stall,
   input wire logic msg_valid,
   input wire emr_msg_t msg_kind,
   input wire logic [3:0] msg_source,
   output logic msg_ready,
   output logic [7:0] got_n,
   output logic [5:0] got_last
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // hub side acceptor
   // ------
   // stall lets the bench hold messages to test that they stand
   assign msg_ready = !stall;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         got_n <= 8'h00;
         got_last <= 6'h00;
      end else if (msg_valid && msg_ready) begin
         got_n <= got_n + 8'h01;
         got_last <= {msg_kind, msg_source};
      end
   end
endmodule

/* bench/error_message_router_test.sv */
module error_message_router_test
   import emr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] ES = EMR_ADDR_SERR;
   localparam logic [9:0] EM = EMR_ADDR_SMI;
   localparam logic [9:0] EC = EMR_ADDR_SCI;
   typedef struct packed {logic [9:0] a; logic [3:0] b; logic c; logic n;} emr_row_t;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, stall, msg_ready, msg_valid;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] flags;
   logic [3:0] msg_source;
   logic [7:0] got_n, n0;
   logic [5:0] got_last;
   emr_msg_t msg_kind;
   emr_row_t rows [16];
   int err_count, n_compared;
   emr_router dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .error_status_register(flags), .msg_ready(msg_ready), .msg_valid(msg_valid),
      .msg_kind(msg_kind), .msg_source(msg_source));
   emr_hub_model hub_u (.hclk(hclk), .hresetn(hresetn), .stall(stall), .msg_valid(msg_valid),
      .msg_kind(msg_kind), .msg_source(msg_source), .msg_ready(msg_ready), .got_n(got_n), .got_last(got_last));
   // ------
   // tasks
   // ------
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && k < 50) begin
         @(posedge hclk);
         k++;
      end
      if (hready !== 1'b1) begin
         err_count++;
         print_verdict();
      end
   endtask
   // hrdata is taken at the rising edge that closes the data phase
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      htrans <= EMR_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= EMR_HSIZE_WORD;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      @(posedge hclk);
      @(posedge hclk);
   endtask
   task automatic mask(input logic [9:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'hFFFFFFFF, rd);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, e);
      chk({31'h0, hresp}, 32'h0);
      bus(1'b1, a, 32'h0, rd);
   endtask
   function automatic emr_msg_t kind_of(input logic [9:0] a);
      return (a == ES) ? EMR_MSG_SERR : (a == EM) ? EMR_MSG_SMI : EMR_MSG_SCI;
   endfunction
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, stall, haddr, hwdata, htrans, hsize, flags} = '0;
      err_count = 0;
      n_compared = 0;
      for (int i = 1; i < 10; i++) rows[i-1] = '{ES, 4'(i), 1'b1, 1'b1};
      rows[9] = '{ES, 4'h5, 1'b0, 1'b0};
      rows[10] = '{ES, 4'h0, 1'b1, 1'b0};
      rows[11] = '{EM, 4'h8, 1'b1, 1'b1};
      rows[12] = '{EM, 4'h7, 1'b1, 1'b1};
      rows[13] = '{EM, 4'h6, 1'b1, 1'b0};
      rows[14] = '{EC, 4'h8, 1'b1, 1'b1};
      rows[15] = '{EC, 4'h7, 1'b1, 1'b1};
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      flags <= 16'hFFFF;
      repeat (5) @(posedge hclk);
      flags <= 16'h0;
      chk({24'h0, got_n}, 32'h0);
      mask(ES, 32'h000003FE);
      mask(EM, 32'h00000180);
      mask(EC, 32'h00000180);
      mask(10'h3FC, 32'h0);
      mask(EMR_ADDR_CTRL, 32'h1);
      foreach (rows[i]) begin
         bus(1'b1, EMR_ADDR_CTRL, {31'h0, rows[i].c}, rd);
         bus(1'b1, rows[i].a, 32'h1 << rows[i].b, rd);
         n0 = got_n;
         flags <= 16'h1 << rows[i].b;
         repeat (20) @(posedge hclk);
         chk({24'h0, got_n - n0}, {31'h0, rows[i].n});
         if (rows[i].n) chk({26'h0, got_last}, {26'h0, kind_of(rows[i].a), rows[i].b});
         flags <= 16'h0;
         bus(1'b1, rows[i].a, 32'h0, rd);
      end
      // two flags at once with the hub stalled: both must queue, lower source first
      bus(1'b1, ES, 32'h180, rd);
      stall <= 1'b1;
      n0 = got_n;
      flags <= 16'h0180;
      repeat (10) @(posedge hclk);
      chk({28'h0, msg_source}, 32'h7);
      chk({31'h0, msg_valid}, 32'h1);
      bus(1'b0, EMR_ADDR_STAT, 32'h0, rd);
      chk(rd, 32'h100);
      stall <= 1'b0;
      repeat (10) @(posedge hclk);
      chk({24'h0, got_n - n0}, 32'h2);
      chk({26'h0, got_last}, {26'h0, EMR_MSG_SERR, 4'h8});
      flags <= 16'h0;
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, ES, 32'h0, rd);
      chk(rd, 32'h0);
      print_verdict();
   end
endmodule
